/* File: verilog/pulse_timer_unit.sv */
// top of the multichannel pulse timer unit: register port, channels, pins, interrupt
`timescale 1ns/1ps
`include "pulse_timer_unit_cfg.svh"
module pulse_timer_unit
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // register port
  input  wire logic [`ADDR_W-1:0]    addr_i,
  input  wire logic [`DATA_W-1:0]    wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [`DATA_W-1:0]    rdata_o,
  // interrupt
  output logic                       irq_o,
  // timer pins, four per channel
  input  wire logic [`NUM_PINS-1:0]  timer_pin_i,
  output logic      [`NUM_PINS-1:0]  timer_pin_o,
  output logic      [`NUM_PINS-1:0]  timer_pin_oe_o
);
  import pulse_timer_unit_pkg::*;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [`NUM_CH-1:0][`CTRL_W-1:0]     ctrl_ff;
  logic [`NUM_CH-1:0][`CTRL_W-1:0]     nxt_ctrl;
  logic [`NUM_CH-1:0][15:0]            pio_ff;
  logic [`NUM_CH-1:0][15:0]            nxt_pio;
  logic [`NUM_CH-1:0]                  start_ff;
  logic [`NUM_CH-1:0]                  nxt_start;
  logic [`NUM_CH-1:0]                  sync_ff;
  logic [`NUM_CH-1:0]                  nxt_sync;
  logic [`STAT_W-1:0]                  stat_ff;
  logic [`STAT_W-1:0]                  nxt_stat;
  logic [`STAT_W-1:0]                  en_ff;
  logic [`STAT_W-1:0]                  nxt_en;
  logic [`DATA_W-1:0]                  rdata_ff;
  logic [`DATA_W-1:0]                  nxt_rdata;
  logic                                irq_ff;
  logic                                nxt_irq;
  logic [`NUM_PINS-1:0]                pin_ff;
  logic [`NUM_PINS-1:0]                nxt_pin;
  logic [`NUM_PINS-1:0]                oe_ff;
  logic [`NUM_PINS-1:0]                nxt_oe;

  // channel wiring
  logic [`NUM_CH-1:0]                  cnt_wr;
  logic [`NUM_CH-1:0]                  cnt_wr_raw;
  logic [`NUM_CH-1:0][3:0]             gr_wr;
  logic [`NUM_CH-1:0]                  tick;
  logic [`NUM_CH-1:0][`CNT_W-1:0]      cnt;
  logic [`NUM_CH-1:0][3:0][`CNT_W-1:0] gr;
  logic [`NUM_CH-1:0][3:0]             match;
  logic [`NUM_CH-1:0][3:0]             capt;
  logic [`NUM_CH-1:0]                  ovf;
  logic [`NUM_CH-1:0]                  clr_local;
  logic [`NUM_CH-1:0]                  clr_any;
  logic                                sync_clr;
  logic [`STAT_W-1:0]                  evt;

  // a macro literal cannot be bit-selected, so the cascade-capable mask lives here
  localparam logic [`NUM_CH-1:0]       casc_ok = `CASC_MASK;

  // true when the address selects register off of channel ch
  function automatic logic ch_hit(input logic [`ADDR_W-1:0] a, input int ch, input logic [2:0] off);
    return (a[7:3] == 5'(ch)) && (a[2:0] == off);
  endfunction

  // pin action on a compare match: hold, drive low, drive high or toggle
  function automatic logic pin_act(input logic [1:0] act, input logic cur);
    logic r;
    r = cur;
    if (act == 2'b01)
    begin
      r = 1'b0;
    end
    else if (act == 2'b10)
    begin
      r = 1'b1;
    end
    else if (act == 2'b11)
    begin
      r = !cur;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // channels and cascade wiring
  // ----------------------------------------------------------------------------
  // pairs one/two and four/five: the lower-numbered channel is the upper half
  assign tick = {1'b0, ovf[5], 2'b00, ovf[2], 1'b0};
  // one mask means one group; a second independent group cannot be expressed
  assign sync_clr = |(clr_local & sync_ff);

  generate
    for (genvar c = 0; c < `NUM_CH; c++)
    begin : g_ch
      timer_channel u_ch
      (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .cnt_wr_i    (cnt_wr[c]),
        .gr_wr_i     (gr_wr[c]),
        .wdata_i     (wdata_i[`CNT_W-1:0]),
        .run_i       (start_ff[c]),
        .cascade_i   (ctrl_ff[c][`CTRL_CASC_BIT] & casc_ok[c]),
        .tick_i      (tick[c]),
        .sync_clr_i  (sync_clr & sync_ff[c]),
        .clr_sel_i   (clr_sel_t'(ctrl_ff[c][`CTRL_CLR_LSB +: 3])),
        .mode_i      (mode_t'(ctrl_ff[c][`CTRL_MODE_LSB +: 2])),
        .pio_i       (pio_ff[c]),
        .pin_in_i    (timer_pin_i[4*c +: 4]),
        .cnt_o       (cnt[c]),
        .gr_o        (gr[c]),
        .match_o     (match[c]),
        .capt_o      (capt[c]),
        .ovf_o       (ovf[c]),
        .clr_local_o (clr_local[c]),
        .clr_any_o   (clr_any[c])
      );
      assign evt[4*c +: 4]        = match[c] | capt[c];
      assign evt[`EVT_OVF_LSB + c] = ovf[c];
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // register writes, status and interrupt
  // ----------------------------------------------------------------------------
  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_pio   = pio_ff;
    nxt_start = start_ff;
    nxt_sync  = sync_ff;
    nxt_en    = en_ff;
    nxt_stat  = stat_ff;
    for (int c = 0; c < `NUM_CH; c++)
    begin
      // cascaded halves are separate words; no wide access joins them
      cnt_wr_raw[c] = wr_i && ch_hit(addr_i, c, `OFF_CNT);
      for (int i = 0; i < 4; i++)
      begin
        gr_wr[c][i] = wr_i && ch_hit(addr_i, c, 3'(`OFF_GR0 + i));
      end
      if (wr_i && ch_hit(addr_i, c, `OFF_CTRL))
      begin
        nxt_ctrl[c] = wdata_i[`CTRL_W-1:0];
      end
      if (wr_i && ch_hit(addr_i, c, `OFF_PIO))
      begin
        nxt_pio[c] = wdata_i[15:0];
      end
    end
    // a write to any counter of the group loads every counter of the group
    cnt_wr = cnt_wr_raw | (sync_ff & {`NUM_CH{|(cnt_wr_raw & sync_ff)}});
    if (wr_i && (addr_i == `ADDR_START))
    begin
      nxt_start = wdata_i[`NUM_CH-1:0];
    end
    else if (wr_i && (addr_i == `ADDR_SYNC))
    begin
      nxt_sync = wdata_i[`NUM_CH-1:0];
    end
    else if (wr_i && (addr_i == `ADDR_CLR))
    begin
      nxt_stat = stat_ff & ~wdata_i[`STAT_W-1:0];
    end
    else if (wr_i && (addr_i == `ADDR_EN))
    begin
      nxt_en = wdata_i[`STAT_W-1:0];
    end
    // an event in the clearing cycle survives
    nxt_stat = nxt_stat | evt;
    nxt_irq  = |(nxt_stat & nxt_en);
  end

  // ----------------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = `RST_DATA;
    if (rd_i)
    begin
      for (int c = 0; c < `NUM_CH; c++)
      begin
        if (ch_hit(addr_i, c, `OFF_CTRL))
        begin
          nxt_rdata = {25'h000_0000, ctrl_ff[c]};
        end
        else if (ch_hit(addr_i, c, `OFF_PIO))
        begin
          nxt_rdata = {16'h0000, pio_ff[c]};
        end
        else if (ch_hit(addr_i, c, `OFF_CNT))
        begin
          nxt_rdata = {16'h0000, cnt[c]};
        end
        for (int i = 0; i < 4; i++)
        begin
          if (ch_hit(addr_i, c, 3'(`OFF_GR0 + i)))
          begin
            nxt_rdata = {16'h0000, gr[c][i]};
          end
        end
      end
      if (addr_i == `ADDR_START)
      begin
        nxt_rdata = {26'h000_0000, start_ff};
      end
      else if (addr_i == `ADDR_SYNC)
      begin
        nxt_rdata = {26'h000_0000, sync_ff};
      end
      else if (addr_i == `ADDR_STAT)
      begin
        nxt_rdata = {2'b00, stat_ff};
      end
      else if (addr_i == `ADDR_EN)
      begin
        nxt_rdata = {2'b00, en_ff};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pin waveforms
  // ----------------------------------------------------------------------------
  always_comb
  begin
    logic [3:0] nib;
    logic [3:0] src;
    mode_t      md;
    int         p;
    nib     = 4'h0;
    src     = 4'h0;
    md      = MODE_NORMAL;
    p       = 0;
    nxt_pin = pin_ff;
    nxt_oe  = oe_ff;
    for (int c = 0; c < `NUM_CH; c++)
    begin
      md  = mode_t'(ctrl_ff[c][`CTRL_MODE_LSB +: 2]);
      src = clr_src_mask(clr_sel_t'(ctrl_ff[c][`CTRL_CLR_LSB +: 3]));
      for (int i = 0; i < 4; i++)
      begin
        p   = 4 * c + i;
        nib = pio_ff[c][4*i +: 4];
        if (md == MODE_PWM1)
        begin
          // first/second drive pin zero, third/fourth drive pin two
          nxt_oe[p] = (i % 2 == 0) && (nib != 4'h0);
          if ((i % 2 == 0) && match[c][i])
          begin
            nxt_pin[p] = pin_act(nib[1:0], pin_ff[p]);
          end
          else if ((i % 2 == 0) && match[c][i | 1])
          begin
            // i | 1 is the odd partner and stays in range for every i
            nxt_pin[p] = pin_act(pio_ff[c][4*(i | 1) +: 2], pin_ff[p]);
          end
        end
        else if (md == MODE_PWM2)
        begin
          // the clear source pin is held off whatever its nibble says
          nxt_oe[p] = (nib != 4'h0) && !src[i];
          if (clr_any[c])
          begin
            nxt_pin[p] = nib[2];
          end
          else if (match[c][i])
          begin
            nxt_pin[p] = pin_act(nib[1:0], pin_ff[p]);
          end
        end
        else
        begin
          // a zero nibble hands the pin back to port use
          nxt_oe[p] = (nib != 4'h0) && !nib[3] && (md == MODE_NORMAL);
          if (match[c][i])
          begin
            nxt_pin[p] = pin_act(nib[1:0], pin_ff[p]);
          end
        end
        // a fresh nibble loads its initial level
        if (wr_i && ch_hit(addr_i, c, `OFF_PIO))
        begin
          nxt_pin[p] = wdata_i[4*i+2];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_ff  <= {`NUM_CH{`RST_CTRL}};
      pio_ff   <= {`NUM_CH{`RST_PIO}};
      start_ff <= `RST_CH_MASK;
      sync_ff  <= `RST_CH_MASK;
      stat_ff  <= `RST_STAT;
      en_ff    <= `RST_STAT;
      rdata_ff <= `RST_DATA;
      irq_ff   <= 1'b0;
      pin_ff   <= 24'h00_0000;
      oe_ff    <= 24'h00_0000;
    end
    else
    begin
      ctrl_ff  <= nxt_ctrl;
      pio_ff   <= nxt_pio;
      start_ff <= nxt_start;
      sync_ff  <= nxt_sync;
      stat_ff  <= nxt_stat;
      en_ff    <= nxt_en;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
      pin_ff   <= nxt_pin;
      oe_ff    <= nxt_oe;
    end
  end

  assign rdata_o        = rdata_ff;
  assign irq_o          = irq_ff;
  assign timer_pin_o    = pin_ff;
  assign timer_pin_oe_o = oe_ff;

endmodule

/* File: verilog/pulse_timer_unit_cfg.svh */
// constants of the multichannel pulse timer unit: offsets, fields, reset values
`ifndef PULSE_TIMER_UNIT_CFG_SVH
`define PULSE_TIMER_UNIT_CFG_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define NUM_CH        6
`define PINS_PER_CH   4
`define NUM_PINS      24
`define CNT_W         16
`define DATA_W        32
`define ADDR_W        8
`define STAT_W        30

// ----------------------------------------------------------------------------
// register map: per channel block at channel*8, globals above
// ----------------------------------------------------------------------------
`define OFF_CTRL      3'h0
`define OFF_PIO       3'h1
`define OFF_CNT       3'h2
`define OFF_GR0       3'h3
`define ADDR_START    8'h30
`define ADDR_SYNC     8'h31
`define ADDR_STAT     8'h32
`define ADDR_CLR      8'h33
`define ADDR_EN       8'h34

// ----------------------------------------------------------------------------
// channel_control_reg fields
// ----------------------------------------------------------------------------
`define CTRL_W        7
`define CTRL_CLR_LSB  0
`define CTRL_MODE_LSB 4
`define CTRL_CASC_BIT 6

// channels that may count from their partner's overflow
`define CASC_MASK     6'h12

// status layout: bit ch*4+i for register i of channel ch, overflow bits above
`define EVT_OVF_LSB   24

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_CTRL      7'h00
`define RST_PIO       16'h0000
`define RST_CNT       16'h0000
`define RST_GR        16'hffff
`define RST_CH_MASK   6'h00
`define RST_STAT      30'h0000_0000
`define RST_DATA      32'h0000_0000

`endif

/* File: verilog/pulse_timer_unit_pkg.sv */
// types and shared decode of the multichannel pulse timer unit
package pulse_timer_unit_pkg;

  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'b00,
    MODE_PWM1   = 2'b01,
    MODE_PWM2   = 2'b10,
    MODE_RSVD   = 2'b11
  } mode_t;

  typedef enum logic [2:0]
  {
    CLR_NONE   = 3'b000,
    CLR_FIRST  = 3'b001,
    CLR_SECOND = 3'b010,
    CLR_SYNC   = 3'b011,
    CLR_OFF4   = 3'b100,
    CLR_THIRD  = 3'b101,
    CLR_FOURTH = 3'b110,
    CLR_OFF7   = 3'b111
  } clr_sel_t;

  // one-hot of the general register acting as counter-clear source
  function automatic logic [3:0] clr_src_mask(input clr_sel_t sel);
    logic [3:0] m;
    m = 4'h0;
    if (sel == CLR_FIRST)
    begin
      m = 4'h1;
    end
    else if (sel == CLR_SECOND)
    begin
      m = 4'h2;
    end
    else if (sel == CLR_THIRD)
    begin
      m = 4'h4;
    end
    else if (sel == CLR_FOURTH)
    begin
      m = 4'h8;
    end
    return m;
  endfunction

endpackage

/* File: verilog/timer_channel.sv */
// one timer channel: up counter, four general registers, compare and capture
`timescale 1ns/1ps
`include "pulse_timer_unit_cfg.svh"
module timer_channel
(
  // clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_b_i,
  // software writes
  input  wire logic                            cnt_wr_i,
  input  wire logic [3:0]                      gr_wr_i,
  input  wire logic [`CNT_W-1:0]               wdata_i,
  // configuration
  input  wire logic                            run_i,
  input  wire logic                            cascade_i,
  input  wire logic                            tick_i,
  input  wire logic                            sync_clr_i,
  input  wire pulse_timer_unit_pkg::clr_sel_t  clr_sel_i,
  input  wire pulse_timer_unit_pkg::mode_t     mode_i,
  input  wire logic [15:0]                     pio_i,
  input  wire logic [3:0]                      pin_in_i,
  // state and events
  output logic      [`CNT_W-1:0]               cnt_o,
  output logic      [3:0][`CNT_W-1:0]          gr_o,
  output logic      [3:0]                      match_o,
  output logic      [3:0]                      capt_o,
  output logic                                 ovf_o,
  output logic                                 clr_local_o,
  output logic                                 clr_any_o
);
  import pulse_timer_unit_pkg::*;

  logic [`CNT_W-1:0]      cnt_ff;
  logic [`CNT_W-1:0]      nxt_cnt;
  logic [3:0][`CNT_W-1:0] gr_ff;
  logic [3:0][`CNT_W-1:0] nxt_gr;
  logic [3:0]             eq_ff;
  logic [3:0]             nxt_eq;
  logic [3:0]             pin_q_ff;
  logic [3:0]             nxt_pin_q;
  logic [3:0]             is_capt;
  logic                   inc;

  always_comb
  begin
    nxt_gr    = gr_ff;
    nxt_pin_q = pin_in_i;
    for (int i = 0; i < 4; i++)
    begin
      // capture only in normal mode, so PWM mode 1 keeps third/fourth as compare
      is_capt[i] = pio_i[4*i+3] && (mode_i == MODE_NORMAL);
      nxt_eq[i]  = (cnt_ff == gr_ff[i]);
      // each register matches on its own, whatever the partner counter does
      match_o[i] = !is_capt[i] && nxt_eq[i] && !eq_ff[i];
      capt_o[i]  = is_capt[i] && pin_in_i[i] && !pin_q_ff[i];
      if (gr_wr_i[i])
      begin
        nxt_gr[i] = wdata_i;
      end
      else if (capt_o[i])
      begin
        nxt_gr[i] = cnt_ff;
      end
    end
    // cascaded upper half steps on the lower half's overflow only
    inc         = cascade_i ? tick_i : run_i;
    ovf_o       = inc && (cnt_ff == 16'hffff);
    // clear source register defines the period
    clr_local_o = |(match_o & clr_src_mask(clr_sel_i));
    clr_any_o   = clr_local_o || ((clr_sel_i == CLR_SYNC) && sync_clr_i);
    nxt_cnt     = cnt_ff;
    if (cnt_wr_i)
    begin
      nxt_cnt = wdata_i;
    end
    else if (clr_any_o)
    begin
      nxt_cnt = `RST_CNT;
    end
    else if (inc)
    begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_ff   <= `RST_CNT;
      gr_ff    <= {4{`RST_GR}};
      eq_ff    <= 4'h0;
      pin_q_ff <= 4'h0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      gr_ff    <= nxt_gr;
      eq_ff    <= nxt_eq;
      pin_q_ff <= nxt_pin_q;
    end
  end

  assign cnt_o = cnt_ff;
  assign gr_o  = gr_ff;

endmodule

/* File: sim/pulse_timer_unit_chk.sv */
// concurrent checks on the pulse timer unit top ports
`timescale 1ns/1ps
`include "pulse_timer_unit_cfg.svh"
module pulse_timer_unit_chk
(
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_b_i,
  // register port
  input wire logic [`ADDR_W-1:0]   addr_i,
  input wire logic [`DATA_W-1:0]   wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [`DATA_W-1:0]   rdata_o,
  // interrupt and pins
  input wire logic                 irq_o,
  input wire logic [`NUM_PINS-1:0] timer_pin_i,
  input wire logic [`NUM_PINS-1:0] timer_pin_o,
  input wire logic [`NUM_PINS-1:0] timer_pin_oe_o
);
  import pulse_timer_unit_pkg::*;
  // ------------------------------------
  // shadow of channel 0 setup and of the interrupt enable mask
  // ------------------------------------
  logic [6:0]  ctrl0_ff;
  logic [6:0]  nxt_ctrl0;
  logic        start0_ff;
  logic        nxt_start0;
  logic [29:0] en_ff;
  logic [29:0] nxt_en;
  always_comb
  begin
    nxt_ctrl0 = (wr_i && addr_i == 8'h00) ? wdata_i[6:0] : ctrl0_ff;
    nxt_start0 = (wr_i && addr_i == `ADDR_START) ? wdata_i[0] : start0_ff;
    nxt_en = (wr_i && addr_i == `ADDR_EN) ? wdata_i[29:0] : en_ff;
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl0_ff <= 7'h00;
      start0_ff <= 1'b0;
      en_ff <= 30'h0000_0000;
    end
    else
    begin
      ctrl0_ff <= nxt_ctrl0;
      start0_ff <= nxt_start0;
      en_ff <= nxt_en;
    end
  end
  // ------------------------------------
  // properties
  // ------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_unmapped;
    rd_i && addr_i > `ADDR_EN |=> rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cnt_hold;
    wr_i && addr_i == 8'h02 && !start0_ff && ctrl0_ff[2:0] == 3'h0 ##2 rd_i && addr_i == 8'h02
      |=> rdata_o[15:0] == $past(wdata_i[15:0], 3);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("stopped counter lost written value");
  property p_pio_off;
    wr_i && addr_i == 8'h01 && wdata_i[3:0] == 4'h0 ##1 !(wr_i && addr_i == 8'h01) |=> !timer_pin_oe_o[0];
  endproperty
  a_pio_off: assert property (p_pio_off) else $error("zero nibble still drives pin");
  property p_reset_off;
    $rose(rst_b_i) |-> timer_pin_oe_o == 24'h00_0000;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("pin driven after reset");
  property p_pwm1_odd;
    ctrl0_ff[5:4] == MODE_PWM1 && $stable(ctrl0_ff) |-> !timer_pin_oe_o[1] && !timer_pin_oe_o[3];
  endproperty
  a_pwm1_odd: assert property (p_pwm1_odd) else $error("odd pin driven in pwm1");
  property p_pwm2_src;
    ctrl0_ff[5:4] == MODE_PWM2 && ctrl0_ff[2:0] == CLR_FOURTH && $stable(ctrl0_ff) |-> !timer_pin_oe_o[3];
  endproperty
  a_pwm2_src: assert property (p_pwm2_src) else $error("clear source pin driven");
  property p_irq_masked;
    en_ff == 30'h0000_0000 && $stable(en_ff) |-> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all sources masked");
  c_irq: cover property ($rose(irq_o));
  c_pwm1: cover property (ctrl0_ff[5:4] == MODE_PWM1 && timer_pin_o[0]);
  c_pwm2: cover property (ctrl0_ff[5:4] == MODE_PWM2 && $fell(timer_pin_o[0]));
endmodule

bind pulse_timer_unit pulse_timer_unit_chk pulse_timer_unit_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .timer_pin_i(timer_pin_i), .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o));

/* File: sim/testbench.sv */
// self-checking bench for the pulse timer unit
`timescale 1ns/1ps
module testbench;
  logic        clk_i   = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr_i  = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [23:0] pin_i   = 24'h00_0000;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic [23:0] pin_o;
  logic [23:0] pin_oe;
  logic [31:0] rv;
  int          fails = 0;
  int          num_checks = 0;
  int          hi;
  int          lo;
  always #2 clk_i = ~clk_i;
  pulse_timer_unit pulse_timer_unit_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe_o(pin_oe));
  // ------------------------------------
  // bus and compare tasks
  // ------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    // one idle edge, so back-to-back writes never drive the strobe twice in one step
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  // edges until pin p is seen at level v, bounded
  task automatic wait_pin(input int p, input logic v, output int n);
    n = 0;
    while (pin_o[p] !== v && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic s_reset;
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h03, 32'h0000_ffff);
    rdchk(8'h32, 32'h0000_0000);
    rdchk(8'h33, 32'h0000_0000);
    rdchk(8'h3f, 32'h0000_0000);
    chk(32'(pin_oe), 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0000);
  endtask
  task automatic s_nibble;
    wr(8'h01, 32'h0000_4444);
    cyc(2);
    chk(32'(pin_oe[3:0]), 32'h0000_000f);
    chk(32'(pin_o[3:0]), 32'h0000_000f);
    wr(8'h01, 32'h0000_0440);
    cyc(2);
    chk(32'(pin_oe[3:0]), 32'h0000_0006);
    wr(8'h00, 32'h0000_0030);
    cyc(2);
    chk(32'(pin_oe[3:0]), 32'h0000_0000);
  endtask
  task automatic s_pwm2;
    logic [2:0] sel [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
    wr(8'h01, 32'h0000_5555);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h00, {25'h0, 4'h4, sel[k]});
      cyc(3);
      chk(32'(pin_oe[3:0]), {28'h000_0000, ~(4'h1 << k)});
    end
    wr(8'h00, 32'h0000_0022);
    wr(8'h03, 32'h0000_0002);
    wr(8'h04, 32'h0000_0009);
    wr(8'h02, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001);
    wait_pin(0, 1'b0, hi);
    wait_pin(0, 1'b1, hi);
    wait_pin(0, 1'b0, hi);
    wait_pin(0, 1'b1, lo);
    chk(32'(hi + lo), 32'h0000_000a);
  endtask
  task automatic s_pwm1;
    wr(8'h30, 32'h0000_0000);
    wr(8'h00, 32'h0000_0016);
    wr(8'h01, 32'h0000_a912);
    wr(8'h03, 32'h0000_0002);
    wr(8'h04, 32'h0000_0006);
    wr(8'h05, 32'h0000_0005);
    wr(8'h06, 32'h0000_000b);
    wr(8'h02, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001);
    chk(32'(pin_oe[3:0]), 32'h0000_0005);
    wait_pin(0, 1'b0, hi);
    wait_pin(0, 1'b1, hi);
    wait_pin(0, 1'b0, hi);
    wait_pin(0, 1'b1, lo);
    chk(32'(hi), 32'h0000_0004);
    chk(32'(hi + lo), 32'h0000_000c);
    wr(8'h30, 32'h0000_0000);
    wr(8'h33, 32'h3fff_ffff);
    pin_i[3:2] <= 2'b11;
    cyc(3);
    rd(8'h32);
    chk(rv & 32'h0000_000c, 32'h0000_0000);
    rdchk(8'h05, 32'h0000_0005);
    wr(8'h00, 32'h0000_0000);
    pin_i[3:2] <= 2'b00;
    cyc(2);
    pin_i[2] <= 1'b1;
    cyc(3);
    rd(8'h32);
    chk(rv & 32'h0000_000c, 32'h0000_0004);
  endtask
  task automatic s_irq;
    wr(8'h01, 32'h0000_0000);
    wr(8'h33, 32'h3fff_ffff);
    wr(8'h03, 32'h0000_0003);
    wr(8'h02, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001);
    cyc(10);
    chk(32'(irq_o), 32'h0000_0000);
    rd(8'h32);
    chk(rv & 32'h0000_0001, 32'h0000_0001);
    wr(8'h34, 32'h0000_0001);
    cyc(2);
    chk(32'(irq_o), 32'h0000_0001);
    wr(8'h30, 32'h0000_0000);
    wr(8'h33, 32'h0000_0001);
    cyc(2);
    chk(32'(irq_o), 32'h0000_0000);
    wr(8'h34, 32'h0000_0000);
  endtask
  task automatic s_cascade;
    wr(8'h08, 32'h0000_0040);
    wr(8'h12, 32'h0000_fffc);
    wr(8'h0a, 32'h0000_0007);
    wr(8'h0b, 32'h0000_0008);
    wr(8'h33, 32'h3fff_ffff);
    wr(8'h30, 32'h0000_0006);
    cyc(12);
    wr(8'h30, 32'h0000_0000);
    rdchk(8'h0a, 32'h0000_0008);
    rd(8'h12);
    chk(32'(rv > 0 && rv < 32), 32'h0000_0001);
    rd(8'h32);
    chk(rv & 32'h0400_0010, 32'h0400_0010);
  endtask
  task automatic s_sync;
    wr(8'h18, 32'h0000_0000);
    wr(8'h31, 32'h0000_0009);
    wr(8'h02, 32'h0000_1234);
    rdchk(8'h02, 32'h0000_1234);
    rdchk(8'h1a, 32'h0000_1234);
    wr(8'h31, 32'h0000_0006);
    wr(8'h0a, 32'h0000_0055);
    rdchk(8'h12, 32'h0000_0055);
    rdchk(8'h02, 32'h0000_1234);
  endtask
  // ------------------------------------
  // main sequence and watchdog
  // ------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    s_reset();
    s_nibble();
    s_pwm2();
    s_pwm1();
    s_irq();
    s_cascade();
    s_sync();
    close_out();
  end
  // whole run takes well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule
